// *** include/chan_link_if.sv ***
`timescale 1ns/10ps
interface chan_link_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        rdata_oe;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output rdata_oe);
  modport host   (output addr, output wdata, output wr, output rd, input rdata, input rdata_oe);
endinterface : chan_link_if

// *** include/chan_pkg.sv ***
// How it works
// - Strap 1 and select 00 at release: memory mode
// - Memory mode replaces registers in address space
// - Strap 0 at release leaves memory mode
// - Memory mode drives read data line always
// - Select 0x1F, config 0x04: pin follows latched done bit
// - Config 0x06 makes pin wired-OR friendly
// - Host adds 0x4000 for second channel
// - Channel decodes 000h to 6FFh, bit7 MSB
// - Host writes nothing to addresses above 6FFh
// - Writes to read-only fields are ignored
// - Real-time status shows live signal level
// - Latched bits set on edge, clear on one
// - Latched bit requests interrupt only when enabled
// - Reset returns configuration to defaults
// - Host writes field bytes in ascending order
// - Lower field byte writes go to transfer
// - Top byte write commits whole field at once
// - Reads mid-write return committed field value
// - Low byte read snapshots field for others
// - Write mid-read overwrites read transfer byte
// - One write and one read transfer register
// - Forty-bit offset field over five byte registers
// - Done flag set after boot; host waits
package chan_pkg;
  localparam logic [15:0] ADDR_LAST            = 16'h06ff;
  localparam logic [15:0] CHAN_B_OFFSET        = 16'h4000;
  localparam logic [15:0] ADDR_PIN_CONFIG_ONE  = 16'h000e;
  localparam logic [15:0] ADDR_PIN_ZERO_SELECT = 16'h0012;
  localparam logic [15:0] ADDR_EDGE_CONFIG     = 16'h0020;
  localparam logic [15:0] ADDR_EVENT_ENABLE    = 16'h0021;
  localparam logic [15:0] ADDR_STATUS_BASE     = 16'h0040;
  localparam logic [15:0] ADDR_CFG_STATUS      = 16'h0040;
  localparam logic [15:0] ADDR_PIN_STATUS      = 16'h0041;
  localparam logic [15:0] ADDR_INT_STATUS      = 16'h0042;
  localparam logic [15:0] ADDR_GLOBAL_EVENT    = 16'h0043;
  localparam logic [15:0] ADDR_FREQ_BYTE0      = 16'h0300;
  localparam logic [15:0] ADDR_FREQ_BYTE4      = 16'h0304;
  localparam int          FREQ_BYTES           = 5;
  localparam int          BOOT_DONE_BIT        = 7;
  localparam logic [7:0]  PIN_CONFIG_RESET     = 8'h00;
  localparam logic [7:0]  PIN_SELECT_RESET     = 8'h00;
  localparam logic [5:0]  EDGE_CONFIG_RESET    = 6'h15;
  localparam logic [7:0]  EVENT_ENABLE_RESET   = 8'h00;
  localparam logic [39:0] FREQ_OFFSET_RESET    = 40'h00_0000_0000;
  localparam logic [3:0]  PIN_MODE_PUSH        = 4'h4;
  localparam logic [3:0]  PIN_MODE_WIRED       = 4'h6;
  localparam logic [7:0]  PIN_SELECT_DONE      = 8'h1f;
  localparam logic [7:0]  PIN_CONFIG_PUSH      = 8'h04;
  localparam logic [7:0]  PIN_CONFIG_WIRED     = 8'h06;
  localparam int          BOOT_CYCLES_DEFAULT  = 64;
  localparam int          CLOCK_MHZ            = 100;
  localparam int          BOOT_WAIT_US         = 100;
  localparam int          BOOT_WAIT_CYCLES     = BOOT_WAIT_US * CLOCK_MHZ;
  localparam int          NVM_DEPTH_DEFAULT    = 256;
  localparam logic [2:0]  HOST_CTRL            = 3'h0;
  localparam logic [2:0]  HOST_TARGET          = 3'h1;
  localparam logic [2:0]  HOST_FREQ_LO         = 3'h2;
  localparam logic [2:0]  HOST_FREQ_HI         = 3'h3;
  localparam logic [2:0]  HOST_CMD             = 3'h4;
  localparam logic [2:0]  HOST_STATUS          = 3'h5;
  localparam logic [2:0]  HOST_RFREQ_LO        = 3'h6;
  localparam logic [2:0]  HOST_RFREQ_HI        = 3'h7;
endpackage : chan_pkg

// *** logic/chan_device.sv ***
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module chan_device #(
  parameter logic [15:0] CHANNEL_BASE = 16'h0000,
  parameter int          BOOT_CYCLES  = chan_pkg::BOOT_CYCLES_DEFAULT,
  parameter int          NVM_DEPTH    = chan_pkg::NVM_DEPTH_DEFAULT
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        TEST_STRAP,
  input  wire logic [1:0]  AUTOCONFIG_SEL,
  input  wire logic [1:0]  EVENT_IN,
  input  wire logic        GENERAL_PIN_ZERO_IN,
  output      logic        GENERAL_PIN_ZERO_OUT,
  output      logic        GENERAL_PIN_ZERO_OE,
  chan_link_if.device      LINK
);
  import chan_pkg::*;

  localparam int NVM_AW = $clog2(NVM_DEPTH);

  logic              rst_q;
  logic              nvm_mode;
  logic              test_q;
  logic [1:0]        ac_q;
  logic [15:0]       off;
  logic              hit;
  logic              wr_reg;
  logic              rd_reg;
  logic [7:0]        pin_config_reg_one;
  logic [7:0]        pin_zero_status_select;
  logic [5:0]        edge_cfg;
  logic [7:0]        event_enable;
  logic [39:0]       freq_offset_field;
  logic [31:0]       wr_xfer;
  logic [39:0]       rd_xfer;
  logic [7:0]        nvm [NVM_DEPTH];
  logic [$clog2(BOOT_CYCLES+1)-1:0] boot_cnt;
  logic              boot_config_done;
  logic [2:0]        ev_sig;
  logic [2:0]        ev_prev;
  logic [2:0]        latched;
  logic [2:0]        clr_bits;
  logic [7:0]        global_event_status;
  logic              int_bit;
  logic              sel_bit;
  logic [7:0]        sel_byte;
  logic [7:0]        next_rdata;
  logic [2:0]        fbyte;

  always_ff @(posedge CLOCK) begin
    rst_q <= RST_N;
  end

  // Straps are caught on the first edge after reset is released
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      nvm_mode <= 1'b0;
      test_q   <= 1'b0;
      ac_q     <= 2'b00;
    end else if (!rst_q) begin
      test_q   <= TEST_STRAP;
      ac_q     <= AUTOCONFIG_SEL;
      nvm_mode <= TEST_STRAP && (AUTOCONFIG_SEL == 2'b00);
    end
  end

  assign off    = LINK.addr - CHANNEL_BASE;
  assign hit    = (LINK.addr >= CHANNEL_BASE) && (off <= ADDR_LAST);
  assign wr_reg = LINK.wr && hit && !nvm_mode;
  assign rd_reg = LINK.rd && hit && !nvm_mode;
  assign fbyte  = 3'(off - ADDR_FREQ_BYTE0);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      boot_cnt         <= '0;
      boot_config_done <= 1'b0;
    end else if (!boot_config_done) begin
      boot_cnt <= boot_cnt + 1'b1;
      if (boot_cnt == ($bits(boot_cnt))'(BOOT_CYCLES - 1)) begin
        boot_config_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pin_config_reg_one     <= PIN_CONFIG_RESET;
      pin_zero_status_select <= PIN_SELECT_RESET;
      edge_cfg               <= EDGE_CONFIG_RESET;
      event_enable           <= EVENT_ENABLE_RESET;
    end else if (wr_reg) begin
      case (off)
        ADDR_PIN_CONFIG_ONE:  pin_config_reg_one     <= LINK.wdata;
        ADDR_PIN_ZERO_SELECT: pin_zero_status_select <= LINK.wdata;
        ADDR_EDGE_CONFIG:     edge_cfg               <= LINK.wdata[5:0];
        ADDR_EVENT_ENABLE:    event_enable           <= LINK.wdata;
        default: ; // Unlisted addresses keep their state; a status write only clears latched bits at ADDR_GLOBAL_EVENT
      endcase
    end
  end

  // Latched events: boot done, two external events
  assign ev_sig   = {boot_config_done, EVENT_IN};
  assign clr_bits = (wr_reg && off == ADDR_GLOBAL_EVENT) ?
                    {LINK.wdata[BOOT_DONE_BIT], LINK.wdata[1:0]} : 3'b000;

  for (genvar i = 0; i < 3; i++) begin : g_latch
    always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
        ev_prev[i] <= 1'b0;
        latched[i] <= 1'b0;
      end else begin
        ev_prev[i] <= ev_sig[i];
        // Set wins over a clear in the same cycle
        if ((ev_sig[i] && !ev_prev[i] && edge_cfg[2*i]) ||
            (!ev_sig[i] && ev_prev[i] && edge_cfg[2*i+1])) begin
          latched[i] <= 1'b1;
        end else if (clr_bits[i]) begin
          latched[i] <= 1'b0;
        end
      end
    end
  end

  assign global_event_status = {latched[2], 5'h00, latched[1:0]};
  assign int_bit = |(global_event_status & event_enable);

  function automatic logic [7:0] status_byte(input logic [4:0] idx);
    case (idx)
      5'h00:   status_byte = {test_q, 5'h00, ac_q};
      5'h01:   status_byte = {7'h00, GENERAL_PIN_ZERO_IN};
      5'h02:   status_byte = {7'h00, int_bit};
      5'h03:   status_byte = global_event_status;
      default: status_byte = 8'h00;
    endcase
  endfunction : status_byte

  // Process form so that the live status signals read by the function wake it up
  always_comb begin
    sel_byte = status_byte(pin_zero_status_select[7:3]);
  end

  assign sel_bit = sel_byte[pin_zero_status_select[2:0]];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      GENERAL_PIN_ZERO_OUT <= 1'b0;
      GENERAL_PIN_ZERO_OE  <= 1'b0;
    end else begin
      case (pin_config_reg_one[3:0])
        PIN_MODE_PUSH: begin
          GENERAL_PIN_ZERO_OUT <= sel_bit;
          GENERAL_PIN_ZERO_OE  <= 1'b1;
        end
        PIN_MODE_WIRED: begin
          GENERAL_PIN_ZERO_OUT <= 1'b0;
          GENERAL_PIN_ZERO_OE  <= !sel_bit;
        end
        default: begin
          GENERAL_PIN_ZERO_OUT <= 1'b0;
          GENERAL_PIN_ZERO_OE  <= 1'b0;
        end
      endcase
    end
  end

  // One shared pair of transfer registers serves every multibyte field
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      freq_offset_field <= FREQ_OFFSET_RESET;
      wr_xfer           <= '0;
      rd_xfer           <= '0;
    end else begin
      if (wr_reg && off >= ADDR_FREQ_BYTE0 && off <= ADDR_FREQ_BYTE4) begin
        rd_xfer[8*fbyte +: 8] <= LINK.wdata;
        if (off == ADDR_FREQ_BYTE4) begin
          freq_offset_field <= {LINK.wdata, wr_xfer};
        end else begin
          wr_xfer[8*fbyte[1:0] +: 8] <= LINK.wdata;
        end
      end else if (rd_reg && off == ADDR_FREQ_BYTE0) begin
        rd_xfer <= freq_offset_field;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (nvm_mode && hit && LINK.wr) begin
      nvm[off[NVM_AW-1:0]] <= LINK.wdata;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (nvm_mode) begin
      next_rdata = nvm[off[NVM_AW-1:0]];
    end else if (off >= ADDR_STATUS_BASE && off < ADDR_STATUS_BASE + 16'h0020) begin
      next_rdata = status_byte(off[4:0]);
    end else if (off == ADDR_FREQ_BYTE0) begin
      next_rdata = freq_offset_field[7:0];
    end else if (off > ADDR_FREQ_BYTE0 && off <= ADDR_FREQ_BYTE4) begin
      next_rdata = rd_xfer[8*fbyte +: 8];
    end else begin
      case (off)
        ADDR_PIN_CONFIG_ONE:  next_rdata = pin_config_reg_one;
        ADDR_PIN_ZERO_SELECT: next_rdata = pin_zero_status_select;
        ADDR_EDGE_CONFIG:     next_rdata = {2'b00, edge_cfg};
        ADDR_EVENT_ENABLE:    next_rdata = event_enable;
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      LINK.rdata    <= 8'h00;
      LINK.rdata_oe <= 1'b0;
    end else begin
      LINK.rdata    <= (LINK.rd && hit) ? next_rdata : 8'h00;
      LINK.rdata_oe <= nvm_mode || (LINK.rd && hit);
    end
  end
endmodule : chan_device

// *** logic/chan_host.sv ***
`timescale 1ns/10ps
module chan_host #(
  parameter int WAIT_CYCLES = chan_pkg::BOOT_WAIT_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [2:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output      logic [31:0] RDATA,
  chan_link_if.host        LINK
);
  import chan_pkg::*;

  typedef enum {S_WAIT, S_POLL, S_POLL_W1, S_POLL_W2, S_IDLE, S_RUN, S_DRAIN,
                S_DRAIN2} state_t;
  typedef enum {OP_WBYTE, OP_RBYTE, OP_WFREQ, OP_RFREQ, OP_BOOT} op_t;

  state_t      state;
  op_t         op;
  logic [2:0]  idx;
  logic [2:0]  last_idx;
  logic [13:0] wait_cnt;
  logic [1:0]  ctrl;
  logic [11:0] tgt_addr;
  logic [7:0]  tgt_data;
  logic [39:0] freq_wr;
  logic [39:0] freq_rd;
  logic [7:0]  last_byte;
  logic        rd_seen;
  logic [2:0]  idx_seen;
  logic [2:0]  idx_issued;
  logic [15:0] step_addr;
  logic [7:0]  step_data;
  logic        step_rd;

  always_comb begin
    step_addr = {4'h0, tgt_addr};
    step_data = 8'h00;
    step_rd   = 1'b0;
    last_idx  = 3'd0;
    case (op)
      OP_WBYTE: step_data = tgt_data;
      OP_RBYTE: step_rd = 1'b1;
      OP_WFREQ: begin
        step_addr = ADDR_FREQ_BYTE0 + {13'h0, idx};
        step_data = freq_wr[8*idx +: 8];
        last_idx  = 3'(FREQ_BYTES - 1);
      end
      OP_RFREQ: begin
        step_addr = ADDR_FREQ_BYTE0 + {13'h0, idx};
        step_rd   = 1'b1;
        last_idx  = 3'(FREQ_BYTES - 1);
      end
      OP_BOOT: begin
        step_addr = (idx == 3'd0) ? ADDR_PIN_ZERO_SELECT : ADDR_PIN_CONFIG_ONE;
        step_data = (idx == 3'd0) ? PIN_SELECT_DONE :
                    (ctrl[1] ? PIN_CONFIG_WIRED : PIN_CONFIG_PUSH);
        last_idx  = 3'd1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl     <= 2'b00;
      tgt_addr <= 12'h000;
      tgt_data <= 8'h00;
      freq_wr  <= 40'h00_0000_0000;
    end else if (WR) begin
      case (ADDR)
        HOST_CTRL:    ctrl <= WDATA[1:0];
        HOST_TARGET: begin
          tgt_addr <= WDATA[11:0];
          tgt_data <= WDATA[23:16];
        end
        HOST_FREQ_LO: freq_wr[31:0] <= WDATA;
        HOST_FREQ_HI: freq_wr[39:32] <= WDATA[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state      <= S_WAIT;
      op         <= OP_WBYTE;
      idx        <= 3'd0;
      wait_cnt   <= '0;
      LINK.addr  <= 16'h0000;
      LINK.wdata <= 8'h00;
      LINK.wr    <= 1'b0;
      LINK.rd    <= 1'b0;
      idx_issued <= 3'd0;
    end else begin
      LINK.wr <= 1'b0;
      LINK.rd <= 1'b0;
      case (state)
        S_WAIT: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (wait_cnt == 14'(WAIT_CYCLES - 1)) begin
            state <= S_POLL;
          end
        end
        S_POLL: begin
          LINK.addr <= ADDR_GLOBAL_EVENT;
          LINK.rd   <= 1'b1;
          state     <= S_POLL_W1;
        end
        S_POLL_W1: state <= S_POLL_W2;
        S_POLL_W2: state <= LINK.rdata[BOOT_DONE_BIT] ? S_IDLE : S_POLL;
        S_IDLE: begin
          idx <= 3'd0;
          if (WR && ADDR == HOST_CMD) begin
            // Targets above ADDR_LAST are never sent to the channel
            if (WDATA[0] && {4'h0, tgt_addr} <= ADDR_LAST) begin
              op <= OP_WBYTE;
              state <= S_RUN;
            end else if (WDATA[1] && {4'h0, tgt_addr} <= ADDR_LAST) begin
              op <= OP_RBYTE;
              state <= S_RUN;
            end else if (WDATA[2]) begin
              op <= OP_WFREQ;
              state <= S_RUN;
            end else if (WDATA[3]) begin
              op <= OP_RFREQ;
              state <= S_RUN;
            end else if (WDATA[4]) begin
              op <= OP_BOOT;
              state <= S_RUN;
            end
          end
        end
        S_RUN: begin
          LINK.addr  <= step_addr + (ctrl[0] ? CHAN_B_OFFSET : 16'h0000);
          LINK.wdata <= step_data;
          LINK.wr    <= !step_rd;
          LINK.rd    <= step_rd;
          idx_issued <= idx;
          idx        <= idx + 1'b1;
          if (idx == last_idx) begin
            state <= S_DRAIN;
          end
        end
        S_DRAIN:  state <= S_DRAIN2;
        S_DRAIN2: state <= S_IDLE;
        default:  state <= S_WAIT;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rd_seen   <= 1'b0;
      idx_seen  <= 3'd0;
      freq_rd   <= 40'h00_0000_0000;
      last_byte <= 8'h00;
    end else begin
      rd_seen  <= LINK.rd && state != S_POLL_W1;
      idx_seen <= idx_issued;
      if (rd_seen) begin
        last_byte <= LINK.rdata;
        if (op == OP_RFREQ) begin
          freq_rd[8*idx_seen +: 8] <= LINK.rdata;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        HOST_CTRL:     RDATA <= {30'h0, ctrl};
        HOST_TARGET:   RDATA <= {8'h00, tgt_data, 4'h0, tgt_addr};
        HOST_FREQ_LO:  RDATA <= freq_wr[31:0];
        HOST_FREQ_HI:  RDATA <= {24'h0, freq_wr[39:32]};
        HOST_STATUS:   RDATA <= {16'h0, last_byte, 6'h0,
                                 state inside {S_IDLE, S_RUN, S_DRAIN, S_DRAIN2},
                                 state != S_IDLE};
        HOST_RFREQ_LO: RDATA <= freq_rd[31:0];
        HOST_RFREQ_HI: RDATA <= {24'h0, freq_rd[39:32]};
        default:       RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule : chan_host

// *** testbench/chan_monitor.sv ***
`timescale 1ns/10ps
module chan_monitor (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        rdata_oe
);
  import chan_pkg::*;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence freq_wr_head;
    wr && addr == ADDR_FREQ_BYTE0 ##1 wr && addr == ADDR_FREQ_BYTE0 + 16'h0001;
  endsequence
  sequence freq_wr_tail;
    wr && addr == ADDR_FREQ_BYTE0 + 16'h0002 ##1 wr && addr == ADDR_FREQ_BYTE0 + 16'h0003
      ##1 wr && addr == ADDR_FREQ_BYTE4;
  endsequence
  sequence freq_rd_head;
    rd && addr == ADDR_FREQ_BYTE0 ##1 rd && addr == ADDR_FREQ_BYTE0 + 16'h0001;
  endsequence
  sequence freq_rd_tail;
    rd && addr == ADDR_FREQ_BYTE0 + 16'h0002 ##1 rd && addr == ADDR_FREQ_BYTE0 + 16'h0003
      ##1 rd && addr == ADDR_FREQ_BYTE4;
  endsequence

  AST_RD_ANSWER: assert property (rd && addr <= ADDR_LAST |=> rdata_oe)
    else $error("read in range got no answer");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  AST_WR_RD_EXCL: assert property (!(wr && rd))
    else $error("write and read strobes together");
  AST_WR_QUIET: assert property (wr && !rdata_oe |=> !rdata_oe)
    else $error("write produced a read answer");
  AST_MEM_DRIVE: assert property (rdata_oe && !$past(rd) |=> rdata_oe)
    else $error("data line released in memory mode");
  AST_ADDR_RANGE: assert property (wr || rd |-> (addr & ~CHAN_B_OFFSET) <= ADDR_LAST)
    else $error("access outside channel range");
  AST_FREQ_WR_ORDER: assert property (freq_wr_head |=> freq_wr_tail)
    else $error("freq field bytes written out of order");
  AST_FREQ_RD_ORDER: assert property (freq_rd_head |=> freq_rd_tail)
    else $error("freq field bytes read out of order");
endmodule : chan_monitor

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb;
  import chan_pkg::*;
  logic        clock          = 1'b0;
  logic        rst_n          = 1'b0;
  logic        test_strap     = 1'b0;
  logic [1:0]  autoconfig_sel = 2'h0;
  logic [1:0]  event_in       = 2'h0;
  logic        general_pin_zero_in       = 1'b0;
  logic        general_pin_zero_out;
  logic        general_pin_zero_oe;
  logic [2:0]  addr           = 3'h0;
  logic [31:0] wdata          = 32'h0;
  logic        wr             = 1'b0;
  logic        rd             = 1'b0;
  logic [31:0] rdata;
  int          err_total      = 0;
  int          n_compared     = 0;
  int          cycles         = 0;
  longint      freq_m         = 0;
  int          wt[4];
  int          rs[$]          = '{0, 0, 0, 0, 0};
  logic [39:0] v;

  chan_link_if link ();
  chan_device #(.BOOT_CYCLES(8)) chan_device_i (.CLOCK(clock), .RST_N(rst_n),
    .TEST_STRAP(test_strap), .AUTOCONFIG_SEL(autoconfig_sel), .EVENT_IN(event_in),
    .GENERAL_PIN_ZERO_IN(general_pin_zero_in), .GENERAL_PIN_ZERO_OUT(general_pin_zero_out), .GENERAL_PIN_ZERO_OE(general_pin_zero_oe), .LINK(link));
  chan_host #(.WAIT_CYCLES(20)) chan_host_i (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINK(link));
  chan_monitor chan_monitor_i (.CLOCK(clock), .RST_N(rst_n), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .rdata_oe(link.rdata_oe));

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk_reg(input string what, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask : chk_pin

  // Model of the freq field with its two transfer registers
  function automatic void m_write(input int a, input int dv);
    if (a >= 'h300 && a < 'h304) wt[a - 'h300] = dv;
    if (a == 'h304) freq_m = {dv[7:0], wt[3][7:0], wt[2][7:0], wt[1][7:0], wt[0][7:0]};
    if (a >= 'h300 && a <= 'h304) rs[a - 'h300] = dv & 'hff;
  endfunction : m_write

  function automatic int m_read(input int a);
    if (a == 'h300) begin
      rs = {};
      for (int i = 0; i < 5; i++) rs.push_back(int'((freq_m >> (8 * i)) & 'hff));
    end
    return rs[a - 'h300];
  endfunction : m_read

  task automatic hw(input logic [2:0] a, input logic [31:0] dv);
    @(posedge clock);
    addr  <= a;
    wdata <= dv;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : hw

  task automatic hr(input logic [2:0] a, output logic [31:0] dv);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    dv = rdata;
  endtask : hr

  task automatic cmd(input logic [31:0] c);
    logic [31:0] s;
    hw(HOST_CMD, c);
    for (int i = 0; i < 60; i++) begin
      hr(HOST_STATUS, s);
      if (s[0] === 1'b0) break;
    end
  endtask : cmd

  task automatic wait_ready();
    logic [31:0] s;
    for (int i = 0; i < 200; i++) begin
      hr(HOST_STATUS, s);
      if (s[1] === 1'b1) break;
    end
    chk_pin("host ready", 1'b1, s[1]);
    repeat (2) @(negedge clock);
  endtask : wait_ready

  task automatic bw(input int a, input int dv);
    hw(HOST_TARGET, {8'h00, 8'(dv), 4'h0, 12'(a)});
    cmd(32'h1);
    m_write(a, dv);
  endtask : bw

  task automatic rchk(input string what, input int a, input int e);
    logic [31:0] s;
    hw(HOST_TARGET, {20'h0, 12'(a)});
    cmd(32'h2);
    hr(HOST_STATUS, s);
    chk_reg(what, 40'(e), 40'(s[15:8]));
  endtask : rchk

  task automatic freq_check(input string what);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [39:0] e;
    cmd(32'h8);
    for (int i = 0; i < 5; i++) e[8*i +: 8] = 8'(m_read('h300 + i));
    hr(HOST_RFREQ_LO, lo);
    hr(HOST_RFREQ_HI, hi);
    chk_reg(what, e, {hi[7:0], lo});
  endtask : freq_check

  initial begin
    void'($urandom(20144));
    autoconfig_sel <= 2'($urandom_range(1, 3));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    wait_ready();
    rchk("edge config", 'h20, 'h15);
    rchk("event enable", 'h21, 0);
    rchk("pin config", 'h0e, 0);
    bw('h40, 'hff);
    rchk("config status", 'h40, autoconfig_sel);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      general_pin_zero_in <= 1'(i);
      rchk("live pin", 'h41, i);
    end
    @(posedge clock);
    event_in <= 2'b01;
    rchk("event latched", 'h43, 'h81);
    bw('h43, 'h00);
    rchk("event zero write", 'h43, 'h81);
    rchk("irq masked", 'h42, 0);
    bw('h21, 'h01);
    rchk("irq enabled", 'h42, 1);
    @(posedge clock);
    event_in <= 2'b00;
    bw('h43, 'h01);
    rchk("event cleared", 'h43, 'h80);
    rchk("irq cleared", 'h42, 0);
    bw('h20, 'h16);
    @(posedge clock);
    event_in <= 2'b01;
    rchk("rise ignored", 'h43, 'h80);
    @(posedge clock);
    event_in <= 2'b00;
    rchk("fall latched", 'h43, 'h81);
    bw('h43, 'h01);
    cmd(32'h10);
    rchk("pin select", 'h12, 'h1f);
    rchk("pin push", 'h0e, 'h04);
    chk_pin("pin drive", 1'b1, general_pin_zero_oe);
    chk_pin("pin level", 1'b1, general_pin_zero_out);
    hw(HOST_CTRL, 32'h2);
    cmd(32'h10);
    rchk("pin wired", 'h0e, 'h06);
    chk_pin("pin released", 1'b0, general_pin_zero_oe);
    bw('h12, 'h18);
    chk_pin("pin pulls", 1'b1, general_pin_zero_oe);
    chk_pin("pin low", 1'b0, general_pin_zero_out);
    hw(HOST_CTRL, 32'h0);
    v = {8'($urandom), 32'($urandom)};
    hw(HOST_FREQ_LO, v[31:0]);
    hw(HOST_FREQ_HI, {24'h0, v[39:32]});
    cmd(32'h4);
    for (int i = 0; i < 5; i++) m_write('h300 + i, int'(v[8*i +: 8]));
    freq_check("freq full write");
    for (int i = 0; i < 4; i++) bw('h300 + i, int'($urandom_range(0, 255)));
    freq_check("freq held");
    rchk("snapshot low", 'h300, m_read('h300));
    bw('h302, int'($urandom_range(0, 255)));
    rchk("snapshot overwrite", 'h302, m_read('h302));
    bw('h304, int'($urandom_range(0, 255)));
    freq_check("freq commit");
    hw(HOST_CTRL, 32'h1);
    bw('h12, 'h0b);
    rchk("other channel read", 'h12, 0);
    hw(HOST_CTRL, 32'h0);
    rchk("other channel write", 'h12, 'h18);
    bw('h7ff, 'h55);
    rchk("refused target", 'h7ff, 'h18);
    @(posedge clock);
    test_strap     <= 1'b1;
    autoconfig_sel <= 2'h0;
    rst_n          <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (40) @(posedge clock);
    @(negedge clock);
    chk_pin("memory drive", 1'b1, link.rdata_oe);
    @(posedge clock);
    test_strap <= 1'b0;
    rst_n      <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wait_ready();
    chk_pin("memory left", 1'b0, link.rdata_oe);
    rchk("select after reset", 'h12, 0);
    test_done();
  end
endmodule : tb
